// >>> dbu_top.sv
/*
  debug uart register block with its serial transmitter, receiver,
  channel test modes and interrupt gating.
  assumes a single-cycle register port on ref_clk, dma and debug
  channel flags on the same clock, and an asynchronous receive pin.
*/
// Summary of operation
// - check_bit_type picks even, odd, zero, one, none
// - channel_test_select picks normal, echo, local, remote
// - enable register writes of one set mask
// - disable register writes of one clear mask
// - mask register reads enabled sources as ones
// - all four registers share one bit layout
// - rx_char_available set on char, cleared by read
// - tx_holding_free low while holding full or disabled
// - transfer done bits follow dma end signals
// - dma buffer bits follow dma buffer signals
// - error flags sticky until clear_error_flags
// - tx_idle_flag only when holding and shifter empty
// - dcc bits follow debug channel status signals
// - received_char in bits 7 to 0
// - baud_divisor read-write in bits 15 to 0
// - divisor zero stops, one direct, else divided
// - clear_error_flags write clears three error flags
// - local loopback: tx feeds rx, pin held high
// - remote loops pin; echo retransmits received bits
`timescale 1ns/1ns
`include "dbu_regs.svh"
module dbu_top #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  input  wire dbu_pkg::dbu_dma_t dma_in,
  input  wire dbu_pkg::dbu_dcc_t dcc_in,
  output logic                   irq
);
  import dbu_pkg::*;

  // address decode
  wire wr_cr   = reg_wr && reg_addr == `DBU_OFF_CR;
  wire wr_mr   = reg_wr && reg_addr == `DBU_OFF_MR;
  wire wr_ier  = reg_wr && reg_addr == `DBU_OFF_IER;
  wire wr_idr  = reg_wr && reg_addr == `DBU_OFF_IDR;
  wire wr_thr  = reg_wr && reg_addr == `DBU_OFF_THR;
  wire wr_brgr = reg_wr && reg_addr == `DBU_OFF_BRGR;
  wire rd_rhr  = reg_rd && reg_addr == `DBU_OFF_RHR;

  wire rst_rx  = wr_cr && reg_wdata[`DBU_CR_RSTRX];
  wire rst_tx  = wr_cr && reg_wdata[`DBU_CR_RSTTX];
  wire clr_err = wr_cr && reg_wdata[`DBU_CR_CLRERR];

  // receive pin synchroniser
  logic rx_meta;
  logic rx_pin_s;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta  <= 1'b1;
      rx_pin_s <= 1'b1;
    end else begin
      rx_meta  <= serial_in_pin;
      rx_pin_s <= rx_meta;
    end
  end

  // software state
  logic [2:0]       par_kind;
  dbu_channel_test_select_t      channel_test_select;
  logic [31:0]      imr;
  logic [DIV_W-1:0] baud_div;
  logic             rx_en;
  logic             tx_en;

  wire has_par = !par_kind[2];
  wire [31:0] next_imr = wr_ier ? (imr | reg_wdata)
                       : wr_idr ? (imr & ~reg_wdata)
                       : imr;
  // a disable in the same word beats an enable
  wire next_rx_en = (reg_wdata[`DBU_CR_RXDIS] || reg_wdata[`DBU_CR_RSTRX])
                    ? 1'b0 : (reg_wdata[`DBU_CR_RXEN] || rx_en);
  wire next_tx_en = (reg_wdata[`DBU_CR_TXDIS] || reg_wdata[`DBU_CR_RSTTX])
                    ? 1'b0 : (reg_wdata[`DBU_CR_TXEN] || tx_en);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_kind <= `DBU_MR_RST;
      channel_test_select   <= CH_NORMAL;
      imr      <= `DBU_IMR_RST;
      baud_div <= `DBU_BRGR_RST;
      rx_en    <= 1'b0;
      tx_en    <= 1'b0;
    end else begin
      imr <= next_imr & `DBU_SR_VALID;
      if (wr_mr) begin
        par_kind <= reg_wdata[`DBU_MR_PAR_LSB +: 3];
        channel_test_select   <= dbu_channel_test_select_t'(reg_wdata[`DBU_MR_CHM_LSB +: 2]);
      end
      if (wr_brgr) begin
        baud_div <= reg_wdata[DIV_W-1:0];
      end
      if (wr_cr) begin
        rx_en <= next_rx_en;
        tx_en <= next_tx_en;
      end
    end
  end

  // remote loopback keeps both engines off the line
  wire rx_run = rx_en && channel_test_select != CH_REMOTE;
  wire tx_run = tx_en && channel_test_select != CH_REMOTE;

  logic tick;
  dbu_baud_gen #(
    .DIV_W   (DIV_W)
  ) u_baud (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .divisor (baud_div),
    .tick    (tick)
  );

  // transmitter
  dbu_tx_state_t tx_st;
  dbu_tx_state_t next_tx_st;
  logic          thr_full;
  logic [7:0]    thr_data;
  logic [7:0]    tx_shift;
  logic [2:0]    tx_bit;
  logic [3:0]    tx_cnt;
  logic          tx_par;

  wire tx_load = tx_st == TX_IDLE && thr_full && tx_run;
  wire tx_adv  = tick && tx_cnt == `DBU_SAMP_LAST;
  wire tx_line = tx_st == TX_START ? 1'b0
               : tx_st == TX_DATA  ? tx_shift[0]
               : tx_st == TX_PAR   ? tx_par
               : 1'b1;

  always_comb begin
    next_tx_st = tx_st;
    case (tx_st)
      TX_IDLE:  if (tx_load) next_tx_st = TX_START;
      TX_START: if (tx_adv) next_tx_st = TX_DATA;
      TX_DATA:  if (tx_adv && tx_bit == `DBU_BIT_LAST) begin
        next_tx_st = has_par ? TX_PAR : TX_STOP;
      end
      TX_PAR:   if (tx_adv) next_tx_st = TX_STOP;
      TX_STOP:  if (tx_adv) next_tx_st = TX_IDLE;
      default:  next_tx_st = TX_IDLE;
    endcase
    if (rst_tx) next_tx_st = TX_IDLE;
  end

  // a write while the holding register is full overwrites it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st    <= TX_IDLE;
      thr_full <= 1'b0;
      thr_data <= 8'h00;
      tx_shift <= 8'h00;
      tx_bit   <= 3'h0;
      tx_cnt   <= 4'h0;
      tx_par   <= 1'b0;
    end else begin
      tx_st    <= next_tx_st;
      thr_full <= !rst_tx && (wr_thr || (thr_full && !tx_load));
      if (wr_thr) thr_data <= reg_wdata[7:0];
      tx_cnt <= (tx_st == TX_IDLE) ? 4'h0 : tx_cnt + {3'h0, tick};
      if (tx_load) begin
        tx_shift <= thr_data;
        tx_bit   <= 3'h0;
        tx_par   <= dbu_parity(par_kind, thr_data);
      end else if (tx_adv && tx_st == TX_DATA) begin
        tx_shift <= {1'b0, tx_shift[7:1]};
        tx_bit   <= tx_bit + 3'h1;
      end
    end
  end

  // receiver
  dbu_rx_state_t rx_st;
  dbu_rx_state_t next_rx_st;
  logic [3:0]    rx_cnt;
  logic [2:0]    rx_bit;
  logic [7:0]    rx_shift;
  logic          rx_par_in;
  logic [7:0]    rhr;
  logic          rx_avail;
  logic          ovr_flag;
  logic          frm_flag;
  logic          par_flag;

  wire rx_in   = channel_test_select == CH_LOCAL ? tx_line : rx_pin_s;
  wire rx_mid  = tick && rx_cnt == `DBU_SAMP_MID;
  wire rx_samp = tick && rx_cnt == `DBU_SAMP_LAST;
  wire rx_done = rx_st == RX_STOP && rx_samp && rx_run;
  wire frm_ev  = rx_done && !rx_in;
  wire par_ev  = rx_done && has_par
                 && rx_par_in != dbu_parity(par_kind, rx_shift);
  wire ovr_ev  = rx_done && rx_avail;

  always_comb begin
    next_rx_st = rx_st;
    case (rx_st)
      RX_IDLE:  if (rx_run && tick && !rx_in) next_rx_st = RX_START;
      // a start bit gone by mid-bit was a glitch
      RX_START: if (rx_mid) next_rx_st = rx_in ? RX_IDLE : RX_DATA;
      RX_DATA:  if (rx_samp && rx_bit == `DBU_BIT_LAST) begin
        next_rx_st = has_par ? RX_PAR : RX_STOP;
      end
      RX_PAR:   if (rx_samp) next_rx_st = RX_STOP;
      RX_STOP:  if (rx_samp) next_rx_st = RX_IDLE;
      default:  next_rx_st = RX_IDLE;
    endcase
    if (rst_rx) next_rx_st = RX_IDLE;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st     <= RX_IDLE;
      rx_cnt    <= 4'h0;
      rx_bit    <= 3'h0;
      rx_shift  <= 8'h00;
      rx_par_in <= 1'b0;
      rhr       <= 8'h00;
    end else begin
      rx_st <= next_rx_st;
      if (rx_st == RX_IDLE || (rx_st == RX_START && rx_mid)) begin
        rx_cnt <= 4'h0;
        rx_bit <= 3'h0;
      end else begin
        rx_cnt <= rx_cnt + {3'h0, tick};
      end
      if (rx_st == RX_DATA && rx_samp) begin
        rx_shift <= {rx_in, rx_shift[7:1]};
        rx_bit   <= rx_bit + 3'h1;
      end
      if (rx_st == RX_PAR && rx_samp) rx_par_in <= rx_in;
      if (rx_done) rhr <= rx_shift;
    end
  end

  // set wins over read and over clear_error_flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_avail <= 1'b0;
      ovr_flag <= 1'b0;
      frm_flag <= 1'b0;
      par_flag <= 1'b0;
    end else begin
      rx_avail <= rx_run && (rx_done || (rx_avail && !rd_rhr));
      ovr_flag <= ovr_ev || (ovr_flag && !clr_err);
      frm_flag <= frm_ev || (frm_flag && !clr_err);
      par_flag <= par_ev || (par_flag && !clr_err);
    end
  end

  // status word
  wire tx_free = tx_run && !thr_full;
  wire tx_idle = tx_free && tx_st == TX_IDLE;
  logic [31:0] sr;
  always_comb begin
    sr = 32'h0000_0000;
    sr[`DBU_SR_RXAV]   = rx_avail;
    sr[`DBU_SR_TXFREE] = tx_free;
    sr[`DBU_SR_RXEND]  = dma_in.rx_end;
    sr[`DBU_SR_TXEND]  = dma_in.tx_end;
    sr[`DBU_SR_OVR]    = ovr_flag;
    sr[`DBU_SR_FRM]    = frm_flag;
    sr[`DBU_SR_PAR]    = par_flag;
    sr[`DBU_SR_TXIDLE] = tx_idle;
    sr[`DBU_SR_TXDMAE] = dma_in.tx_buf_empty;
    sr[`DBU_SR_RXDMAF] = dma_in.rx_buf_full;
    sr[`DBU_SR_DCCW]   = dcc_in.write_pending;
    sr[`DBU_SR_DCCR]   = dcc_in.read_pending;
  end

  // read mux; write-only and unmapped offsets read zero
  wire [31:0] mr_view = {16'h0000, channel_test_select, 2'h0, par_kind, 9'h000};
  wire [31:0] rd_mux =
      reg_addr == `DBU_OFF_MR   ? mr_view
    : reg_addr == `DBU_OFF_IMR  ? imr
    : reg_addr == `DBU_OFF_SR   ? sr
    : reg_addr == `DBU_OFF_RHR  ? {24'h00_0000, rhr}
    : reg_addr == `DBU_OFF_BRGR ? {{(32-DIV_W){1'b0}}, baud_div}
    : 32'h0000_0000;

  // out pin is registered so mode changes never glitch the line
  wire next_out = channel_test_select == CH_NORMAL ? tx_line
                : channel_test_select == CH_LOCAL  ? 1'b1
                : rx_pin_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata      <= 32'h0000_0000;
      serial_out_pin <= 1'b1;
      irq            <= 1'b0;
    end else begin
      reg_rdata      <= reg_rd ? rd_mux : 32'h0000_0000;
      serial_out_pin <= next_out;
      irq            <= |(sr & imr);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_local_held;
    channel_test_select == CH_LOCAL [*2];
  endsequence

  sequence s_echo_held;
    channel_test_select == CH_ECHO [*2];
  endsequence

  mask_set_a: assert property (
    wr_ier |=> (imr & $past(reg_wdata) & `DBU_SR_VALID)
               == ($past(reg_wdata) & `DBU_SR_VALID)
  ) else $error("enable write did not set mask bits");

  mask_clear_a: assert property (
    wr_idr |=> (imr & $past(reg_wdata)) == 32'h0000_0000
  ) else $error("disable write did not clear mask bits");

  mask_read_a: assert property (
    reg_rd && reg_addr == `DBU_OFF_IMR |=> reg_rdata == $past(imr)
  ) else $error("mask read mismatch");

  rx_read_a: assert property (
    rd_rhr && !rx_done |=> !rx_avail
  ) else $error("read did not clear character flag");

  rx_set_a: assert property (
    rx_done |=> rx_avail && rhr == $past(rx_shift)
  ) else $error("finished character not presented");

  thr_busy_a: assert property (
    wr_thr && !rst_tx |=> !sr[`DBU_SR_TXFREE] && !sr[`DBU_SR_TXIDLE]
  ) else $error("holding free right after a write");

  dma_follow_a: assert property (
    reg_rd && reg_addr == `DBU_OFF_SR
    |=> reg_rdata[`DBU_SR_RXEND] == $past(dma_in.rx_end)
        && reg_rdata[`DBU_SR_RXDMAF] == $past(dma_in.rx_buf_full)
  ) else $error("dma status not reflected");

  err_sticky_a: assert property (
    par_flag && !clr_err |=> par_flag
  ) else $error("parity flag lost without clear");

  err_clear_a: assert property (
    clr_err && !rx_done |=> !ovr_flag && !frm_flag && !par_flag
  ) else $error("error flags survived clear");

  overrun_a: assert property (
    rx_done && rx_avail |=> ovr_flag
  ) else $error("overrun not flagged");

  tx_check_a: assert property (
    tx_load |=> tx_par == dbu_parity($past(par_kind), $past(thr_data))
  ) else $error("check bit wrong for selected type");

  baud_write_a: assert property (
    wr_brgr |=> baud_div == $past(reg_wdata[DIV_W-1:0])
  ) else $error("divisor not stored");

  local_loop_a: assert property (
    s_local_held |-> serial_out_pin
  ) else $error("out pin not idle in local loopback");

  echo_path_a: assert property (
    s_echo_held |-> serial_out_pin == $past(rx_pin_s)
  ) else $error("echo does not follow receive pin");

  irq_gate_a: assert property (
    |(sr & imr) |=> irq
  ) else $error("interrupt missing for enabled source");

endmodule : dbu_top

// >>> dbu_regs.svh
/*
  register offsets, field positions, reset values and timing counts
  for the debug uart; included by bare name, definitions only.
*/
`ifndef DBU_REGS_SVH
`define DBU_REGS_SVH

`define DBU_OFF_CR     8'h00
`define DBU_OFF_MR     8'h04
`define DBU_OFF_IER    8'h08
`define DBU_OFF_IDR    8'h0C
`define DBU_OFF_IMR    8'h10
`define DBU_OFF_SR     8'h14
`define DBU_OFF_RHR    8'h18
`define DBU_OFF_THR    8'h1C
`define DBU_OFF_BRGR   8'h20

`define DBU_CR_RSTRX   2
`define DBU_CR_RSTTX   3
`define DBU_CR_RXEN    4
`define DBU_CR_RXDIS   5
`define DBU_CR_TXEN    6
`define DBU_CR_TXDIS   7
`define DBU_CR_CLRERR  8

`define DBU_MR_PAR_LSB 9
`define DBU_MR_CHM_LSB 14

`define DBU_SR_RXAV    0
`define DBU_SR_TXFREE  1
`define DBU_SR_RXEND   3
`define DBU_SR_TXEND   4
`define DBU_SR_OVR     5
`define DBU_SR_FRM     6
`define DBU_SR_PAR     7
`define DBU_SR_TXIDLE  9
`define DBU_SR_TXDMAE  11
`define DBU_SR_RXDMAF  12
`define DBU_SR_DCCW    30
`define DBU_SR_DCCR    31
`define DBU_SR_VALID   32'hC000_1AFB

`define DBU_MR_RST     3'h0
`define DBU_IMR_RST    32'h0000_0000
`define DBU_BRGR_RST   16'h0000

`define DBU_SAMP_MID   4'h7
`define DBU_SAMP_LAST  4'hF
`define DBU_BIT_LAST   3'h7

`endif

// >>> dbu_pkg.sv
/*
  types shared by the debug uart: state encodings, channel modes,
  side-band signal groups and the check-bit decode.
  assumes nothing beyond a systemverilog compiler.
*/
package dbu_pkg;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } dbu_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } dbu_rx_state_t;

  typedef enum logic [1:0] {
    CH_NORMAL = 2'h0,
    CH_ECHO   = 2'h1,
    CH_LOCAL  = 2'h2,
    CH_REMOTE = 2'h3
  } dbu_channel_test_select_t;

  typedef struct packed {
    logic rx_end;
    logic tx_end;
    logic tx_buf_empty;
    logic rx_buf_full;
  } dbu_dma_t;

  typedef struct packed {
    logic write_pending;
    logic read_pending;
  } dbu_dcc_t;

  // value of the check bit for a character; meaningless when kind[2]
  function automatic logic dbu_parity(input logic [2:0] kind,
                                      input logic [7:0] data);
    logic p;
    p = 1'b0;
    case (kind[1:0])
      2'h0:    p = ^data;
      2'h1:    p = ~^data;
      2'h2:    p = 1'b0;
      default: p = 1'b1;
    endcase
    return p;
  endfunction : dbu_parity

endpackage : dbu_pkg

// >>> dbu_baud_gen.sv
/*
  sample tick generator for the debug uart: one tick every divisor
  clocks, sixteen ticks make one bit.
  assumes the divisor comes from a register on the same clock.
*/
`timescale 1ns/1ns
module dbu_baud_gen #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  import dbu_pkg::*;

  logic [DIV_W-1:0] cnt;
  wire              run = divisor != '0;
  wire              wrap = cnt >= divisor - DIV_W'(1);

  assign tick = run && wrap;

  // a lowered divisor must not strand the counter above it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!run || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + DIV_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  stopped_clock_a: assert property (
    divisor == '0 |-> !tick
  ) else $error("baud tick while divisor is zero");

  direct_clock_a: assert property (
    divisor == DIV_W'(1) [*2] |-> tick
  ) else $error("divisor one must tick every clock");

endmodule : dbu_baud_gen

// >>> dbu_term_model.sv
/*
  remote serial terminal model for the debug uart: sends frames on
  the receive pin and captures frames from the transmit pin.
  assumes a baud divisor of one, so one bit lasts BIT_CLKS clocks.
*/
`timescale 1ns/1ns
module dbu_term_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic ref_clk,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  // the line idles high between frames, as a real terminal leaves it
  initial serial_in_pin = 1'b1;

  // start, eight data bits lsb first, optional check bit, one stop
  task automatic send(input logic [7:0] d, input logic par_on,
                      input logic par_bit, input logic stop_bit);
    logic [10:0] fr;
    int          n;
    fr = {stop_bit, par_bit, d, 1'b0};
    n = par_on ? 11 : 10;
    if (!par_on) begin
      fr[9] = stop_bit;
    end
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= fr[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    serial_in_pin <= 1'b1;
  endtask : send

  // waits a bounded time for a start bit, then samples mid-bit
  task automatic recv(input logic par_on, output logic [7:0] d,
                      output logic p, output logic ok);
    int w;
    w = 0;
    ok = 1'b0;
    d = 8'h00;
    p = 1'b0;
    while (serial_out_pin !== 1'b0 && w < 4000) begin
      @(posedge ref_clk);
      w++;
    end
    if (w < 4000) begin
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge ref_clk);
        d[i] = serial_out_pin;
      end
      if (par_on) begin
        repeat (BIT_CLKS) @(posedge ref_clk);
        p = serial_out_pin;
      end
      repeat (BIT_CLKS) @(posedge ref_clk);
      ok = (serial_out_pin === 1'b1);
    end
  endtask : recv
endmodule : dbu_term_model

// >>> dbu_top_tb_top.sv
/*
  self-checking bench for the debug uart register block.
  assumes dbu_top and the terminal model are compiled before it.
*/
`timescale 1ns/1ns
`include "dbu_regs.svh"
module dbu_top_tb_top;
  import dbu_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        serial_in_pin;
  logic        serial_out_pin;
  dbu_dma_t    dma_in;
  dbu_dcc_t    dcc_in;
  logic        irq;
  int          num_errors;
  int          compares;
  logic [7:0]  got;
  logic [7:0]  ch;
  logic        pb;
  logic        ok;
  int          lows;
  logic [31:0] sr_map [6] = '{32'h0000_0008, 32'h0000_0010,
    32'h0000_0800, 32'h0000_1000, 32'h4000_0000, 32'h8000_0000};

  dbu_top i_dbu_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .dma_in(dma_in), .dcc_in(dcc_in), .irq(irq));
  dbu_term_model i_dbu_term_model (.ref_clk(ref_clk),
    .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // one idle edge so the strobe drops for a cycle before a following write raises it again
    @(posedge ref_clk);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
    chk(what, exp, d & mask);
  endtask : rdchk

  function automatic logic want_par(input int k, input logic [7:0] d);
    return (k == 0) ? ^d : (k == 1) ? ~^d : (k == 3);
  endfunction : want_par

  // a character from the terminal, then time for the receiver to land it
  task automatic rx_frame(input logic [7:0] d, input logic bad,
                          input logic stop_bit);
    i_dbu_term_model.send(d, 1'b1, want_par(0, d) ^ bad, stop_bit);
    repeat (20) @(posedge ref_clk);
  endtask : rx_frame

  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dma_in = '0;
    dcc_in = '0;
    num_errors = 0;
    compares = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk("mask reset", `DBU_OFF_IMR, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("baud reset", `DBU_OFF_BRGR, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("holding reset", `DBU_OFF_RHR, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("tx off flags", `DBU_OFF_SR, 32'h0000_0202, 32'h0000_0000);
    rdchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`DBU_OFF_BRGR, 32'hFFFF_ABCD);
    rdchk("baud field", `DBU_OFF_BRGR, 32'hFFFF_FFFF, 32'h0000_ABCD);
    wr(`DBU_OFF_BRGR, 32'h0000_0001);
    wr(`DBU_OFF_IER, 32'hFFFF_FFFF);
    rdchk("mask all", `DBU_OFF_IMR, 32'hFFFF_FFFF, 32'hC000_1AFB);
    wr(`DBU_OFF_IDR, 32'h0000_0001);
    wr(`DBU_OFF_IER, 32'h0000_0000);
    rdchk("mask one off", `DBU_OFF_IMR, 32'hFFFF_FFFF, 32'hC000_1AFA);
    wr(`DBU_OFF_IDR, 32'hFFFF_FFFF);
    wr(`DBU_OFF_IER, 32'h4000_0000);
    rdchk("mask dcc", `DBU_OFF_IMR, 32'hFFFF_FFFF, 32'h4000_0000);
    for (int j = 0; j < 6; j++) begin
      {dma_in, dcc_in} <= 6'h20 >> j;
      repeat (3) @(posedge ref_clk);
      chk("irq", {31'h0, j == 4}, {31'h0, irq});
      rdchk("side", `DBU_OFF_SR, 32'hC000_1818, sr_map[j]);
    end
    {dma_in, dcc_in} <= 6'h00;
    repeat (3) @(posedge ref_clk);
    chk("irq low", 32'h0, {31'h0, irq});
    wr(`DBU_OFF_IDR, 32'hFFFF_FFFF);
    wr(`DBU_OFF_CR, 32'h0000_0050);
    for (int k = 0; k < 5; k++) begin
      ch = 8'h31 + 8'(k);
      wr(`DBU_OFF_MR, 32'(k) << `DBU_MR_PAR_LSB);
      wr(`DBU_OFF_THR, {24'h00_0000, ch});
      fork
        i_dbu_term_model.recv(k < 4, got, pb, ok);
        if (k == 0) begin
          repeat (40) @(posedge ref_clk);
          rdchk("tx busy", `DBU_OFF_SR, 32'h0000_0200, 32'h0);
        end
      join
      chk("tx char", {24'h0, ch}, {24'h0, got});
      chk("tx par", {31'h0, k < 4 && want_par(k, ch)}, {31'h0, pb});
      chk("tx stop", 32'h1, {31'h0, ok});
    end
    repeat (30) @(posedge ref_clk);
    rdchk("tx done", `DBU_OFF_SR, 32'h0000_0202, 32'h0000_0202);
    wr(`DBU_OFF_MR, 32'h0000_0000);
    rx_frame(8'h3C, 1'b0, 1'b1);
    rdchk("rx ready", `DBU_OFF_SR, 32'h0000_00E1, 32'h0000_0001);
    rdchk("rx char", `DBU_OFF_RHR, 32'hFFFF_FFFF, 32'h0000_003C);
    rdchk("rx read", `DBU_OFF_SR, 32'h0000_0001, 32'h0000_0000);
    rx_frame(8'h3C, 1'b1, 1'b1);
    rdchk("rx drain", `DBU_OFF_RHR, 32'hFFFF_FFFF, 32'h0000_003C);
    rdchk("parity err", `DBU_OFF_SR, 32'h0000_00E0, 32'h0000_0080);
    rx_frame(8'h5A, 1'b0, 1'b0);
    rdchk("rx drain", `DBU_OFF_RHR, 32'hFFFF_FFFF, 32'h0000_005A);
    rdchk("frame err", `DBU_OFF_SR, 32'h0000_00E0, 32'h0000_00C0);
    rx_frame(8'h11, 1'b0, 1'b1);
    rx_frame(8'h22, 1'b0, 1'b1);
    wr(`DBU_OFF_CR, 32'h0000_0000);
    rdchk("overrun", `DBU_OFF_SR, 32'h0000_00E0, 32'h0000_00E0);
    wr(`DBU_OFF_CR, 32'h0000_0100);
    rdchk("errs cleared", `DBU_OFF_SR, 32'h0000_00E0, 32'h0);
    rdchk("rx drain", `DBU_OFF_RHR, 32'hFFFF_FFFF, 32'h0000_0022);
    wr(`DBU_OFF_MR, 32'h0000_8000);
    wr(`DBU_OFF_THR, 32'h0000_0096);
    lows = 0;
    fork
      i_dbu_term_model.send(8'h00, 1'b1, 1'b0, 1'b1);
      for (int c = 0; c < 240; c++) begin
        @(posedge ref_clk);
        lows += (serial_out_pin !== 1'b1);
      end
    join
    chk("loop pin idle", 32'h0, 32'(lows));
    rdchk("loop char", `DBU_OFF_RHR, 32'hFFFF_FFFF, 32'h0000_0096);
    for (int m = 1; m < 4; m += 2) begin
      ch = 8'hC3 + 8'(m);
      wr(`DBU_OFF_MR, (32'(m) << `DBU_MR_CHM_LSB) | 32'h0000_0800);
      fork
        i_dbu_term_model.send(ch, 1'b0, 1'b0, 1'b1);
        i_dbu_term_model.recv(1'b0, got, pb, ok);
      join
      chk("echo char", {24'h0, ch}, {24'h0, got});
      chk("echo stop", 32'h1, {31'h0, ok});
    end
    wr(`DBU_OFF_MR, 32'h0000_0000);
    rx_frame(8'h5A, 1'b0, 1'b1);
    rdchk("rx again", `DBU_OFF_SR, 32'h0000_0001, 32'h0000_0001);
    wr(`DBU_OFF_CR, 32'h0000_00AC);
    rdchk("all off", `DBU_OFF_SR, 32'h0000_0203, 32'h0);
    final_report();
  end
endmodule : dbu_top_tb_top
